// >>> design/rbs_sequencer.sv
`timescale 1ns/100ps
// How it works
// RL1 - Supply below threshold holds core, peripherals reset
// RL2 - Hold reset 65536 cycles after supply rises
// RL3 - Power-down reset uses threshold minus hysteresis
// RL4 - External reset pin low forces full reset
// RL5 - Reset empties stacks, masks interrupts, clears status
// RL6 - Fetch starts at ROM address 0x0800
// RL7 - Boot code set jumps to flash 0x2200
// RL8 - Boot code clear boots from external device
// RL9 - Boot code set refuses utility and debugger
// RL10 - Only user program routines clear boot code
// RL11 - Secure erase wipes flash; plain clear keeps it
// RL12 - Sectors 256/256/3584 words at 0x2000/2100/2200
// RL13 - Erased user bytes read all zeros
// RL14 - Software should leave flash control to utility
// RL15 - Processor clock runs at twice input clock (here processor_clock_output runs at half the sys_clk_in rate)
// RL16 - External clock never halts or changes frequency
// RL17 - Supply dip restarts stretch count from zero
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int STRETCH_CYCLES = RBS_STRETCH_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        clk_en_in,
  // Supply comparators and reset pin
  input  wire logic        supply_above_vrst_in,
  input  wire logic        supply_below_vhyst_in,
  input  wire logic        ext_reset_n_in,
  // Boot code and ROM routine requests from the running program
  input  wire logic        boot_code_nv_in,
  input  wire logic        secure_erase_req_in,
  input  wire logic        boot_clear_req_in,
  input  wire logic        erase_done_in,
  input  wire logic        debug_req_in,
  // Flash sector lookup
  input  wire logic [13:0] pm_addr_in,
  input  wire logic [1:0]  user_byte_sel_in,
  input  wire logic [31:0] user_bytes_nv_in,
  input  wire logic        user_bytes_erased_in,
  // Reset outputs
  output logic             core_reset_out,
  output logic             periph_reset_out,
  output logic [3:0]       stack_ptr_out,
  output logic [15:0]      irq_mask_out,
  output logic [7:0]       mode_status_word_out,
  // Boot control
  output logic [13:0]      fetch_addr_out,
  output logic             fetch_valid_out,
  output logic             ext_boot_out,
  output logic             flash_erase_out,
  output logic             boot_code_clear_out,
  output logic             debug_ack_out,
  output logic             debug_lock_out,
  // Flash decode and user bytes
  output logic [1:0]       flash_sector_out,
  output logic             flash_hit_out,
  output logic [7:0]       user_byte_out,
  // Processor clock
  output logic             processor_clock_output
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  rbs_sync_if sync_if ();

  rbs_sync #(.RESET_VAL(1'b0)) u_sync_ok (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .clk_en_in  (clk_en_in),
    .async_in   (supply_above_vrst_in),
    .level_out  (sync_if.supply_ok)
  );
  rbs_sync #(.RESET_VAL(1'b1)) u_sync_low (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .clk_en_in  (clk_en_in),
    .async_in   (supply_below_vhyst_in),
    .level_out  (sync_if.supply_low)
  );
  rbs_sync #(.RESET_VAL(1'b0)) u_sync_rst (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .clk_en_in  (clk_en_in),
    .async_in   (ext_reset_n_in),
    .level_out  (sync_if.ext_reset_n)
  );

  // ----------------------------------------------------------------------
  // Power-good with hysteresis
  // ----------------------------------------------------------------------
  logic power_good;
  // Rise needs the upper threshold, fall needs the lower one, so noise between them does nothing
  wire  next_power_good = power_good ? !sync_if.supply_low   // [RL3]
                                     : sync_if.supply_ok;    // [RL1]
  wire  reset_cause     = !next_power_good || !sync_if.ext_reset_n;  // [RL4]

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  rbs_state_t state;
  rbs_state_t next_state;
  logic [31:0] stretch_cnt;
  localparam logic [31:0] STRETCH_LAST = 32'(STRETCH_CYCLES - 1);
  wire  stretch_done = (stretch_cnt == STRETCH_LAST);
  logic boot_code;                     // Working copy of the nonvolatile boot code

  always_comb begin
    next_state = state;
    unique case (state)
      RBS_ST_RESET:     next_state = RBS_ST_STRETCH;
      RBS_ST_STRETCH:   if (stretch_done) next_state = RBS_ST_ROM_CHECK;       // [RL2]
      RBS_ST_ROM_CHECK: next_state = boot_code ? RBS_ST_FLASH_RUN              // [RL7]
                                               : RBS_ST_EXT_BOOT;              // [RL8]
      RBS_ST_FLASH_RUN: if (secure_erase_req_in) next_state = RBS_ST_ERASE;    // [RL10]
      RBS_ST_ERASE:     if (erase_done_in) next_state = RBS_ST_FLASH_RUN;      // [RL11]
      RBS_ST_EXT_BOOT:  next_state = RBS_ST_EXT_BOOT;
    endcase
  end

  // State register; any reset cause drops back and restarts the count
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state       <= RBS_ST_RESET;
      stretch_cnt <= '0;
      power_good  <= 1'b0;
    end else if (clk_en_in) begin
      power_good <= next_power_good;
      if (reset_cause) begin
        state       <= RBS_ST_RESET;                 // [RL1] [RL4]
        stretch_cnt <= '0;                           // [RL17]
      end else begin
        state       <= next_state;
        stretch_cnt <= (state == RBS_ST_STRETCH) ? stretch_cnt + 32'h1 : '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Boot code copy: loaded at reset exit, cleared only by the ROM routines
  // ----------------------------------------------------------------------
  wire in_reset   = (state == RBS_ST_RESET) || (state == RBS_ST_STRETCH);
  wire user_runs  = (state == RBS_ST_FLASH_RUN);
  wire clear_now  = user_runs && boot_clear_req_in;                        // [RL10]
  wire erase_end  = (state == RBS_ST_ERASE) && erase_done_in;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_code <= 1'b0;
    end else if (clk_en_in) begin
      if (in_reset) begin
        boot_code <= boot_code_nv_in;
      end else if (clear_now || erase_end) begin
        boot_code <= 1'b0;                           // [RL11]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Flash sector decode and user bytes
  // ----------------------------------------------------------------------
  wire       hit    = (pm_addr_in >= RBS_SECT0_BASE) && (pm_addr_in <= RBS_SECT2_LAST);  // [RL12]
  wire [1:0] sector = (pm_addr_in >= RBS_SECT2_BASE) ? 2'h2 :
                      (pm_addr_in >= RBS_SECT1_BASE) ? 2'h1 : 2'h0;
  wire [7:0] ubyte  = user_bytes_erased_in ? RBS_USER_BYTE_ERASED                        // [RL13]
                                           : user_bytes_nv_in[{user_byte_sel_in, 3'h0} +: 8];

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  wire locked = boot_code;                                                   // [RL9]
  // Reset outputs follow the next state, so they fall in the very cycle that the ROM start
  // address is first shown; a set boot code would otherwise skip the ROM fetch altogether
  wire next_in_reset = reset_cause || (next_state == RBS_ST_RESET) || (next_state == RBS_ST_STRETCH);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_reset_out       <= 1'b1;
      periph_reset_out     <= 1'b1;
      stack_ptr_out        <= RBS_STACK_EMPTY;
      irq_mask_out         <= RBS_IMASK_RESET;
      mode_status_word_out <= RBS_MODE_STATUS_WORD_RESET;
      fetch_addr_out       <= RBS_ROM_START;
      fetch_valid_out      <= 1'b0;
      ext_boot_out         <= 1'b0;
      flash_erase_out      <= 1'b0;
      boot_code_clear_out  <= 1'b0;
      debug_ack_out        <= 1'b0;
      debug_lock_out       <= 1'b0;
      flash_sector_out     <= 2'h0;
      flash_hit_out        <= 1'b0;
      user_byte_out        <= RBS_USER_BYTE_ERASED;
    end else if (clk_en_in) begin
      core_reset_out   <= next_in_reset;                                    // [RL1] [RL2]
      periph_reset_out <= next_in_reset;                                    // [RL1]
      if (in_reset) begin
        stack_ptr_out        <= RBS_STACK_EMPTY;                            // [RL5]
        irq_mask_out         <= RBS_IMASK_RESET;                            // [RL5]
        mode_status_word_out <= RBS_MODE_STATUS_WORD_RESET;                            // [RL5]
      end
      fetch_valid_out <= !next_in_reset;                                    // [RL6]
      if (state == RBS_ST_STRETCH || state == RBS_ST_RESET) begin
        fetch_addr_out <= RBS_ROM_START;                                    // [RL6]
      end else if (state == RBS_ST_ROM_CHECK && boot_code) begin
        fetch_addr_out <= RBS_APP_START;                                    // [RL7]
      end
      ext_boot_out        <= (state == RBS_ST_ROM_CHECK && !boot_code) || (state == RBS_ST_EXT_BOOT);  // [RL8]
      flash_erase_out     <= (state == RBS_ST_ERASE);                       // [RL11]
      boot_code_clear_out <= clear_now || erase_end;
      debug_lock_out      <= locked;
      debug_ack_out       <= debug_req_in && !locked && !in_reset;          // [RL9]
      flash_sector_out    <= sector;
      flash_hit_out       <= hit;
      user_byte_out       <= ubyte;
    end
  end

  // ----------------------------------------------------------------------
  // Processor clock: toggles on each enabled sys_clk_in rising edge, giving half the sys_clk_in rate,
  // so only the input clock rate when sys_clk_in is already the doubled internal clock. Limitation: the
  // real doubler is analog; here sys_clk_in stands for the processor cycle.
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      processor_clock_output <= 1'b0;
    end else if (clk_en_in) begin
      processor_clock_output <= !processor_clock_output;                    // [RL15]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_reset_exit;
    state == RBS_ST_STRETCH && stretch_done && !reset_cause && clk_en_in;
  endsequence

  // Erase runs in two steps: the wipe first, then the boot code clear
  sequence s_erase_busy;
    clk_en_in && !reset_cause && state == RBS_ST_ERASE && !erase_done_in;
  endsequence
  sequence s_erase_end;
    clk_en_in && !reset_cause && erase_end;
  endsequence

  supply_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)   // [RL1]
    (clk_en_in && !next_power_good) |=> core_reset_out && periph_reset_out)
    else $error("reset not held while supply low");
  stretch_len_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)   // [RL2]
    (clk_en_in && !reset_cause && state == RBS_ST_STRETCH && !stretch_done) |=> state == RBS_ST_STRETCH)
    else $error("stretch ended early");
  hyst_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)     // [RL3]
    (clk_en_in && power_good && !sync_if.supply_low) |=> power_good)
    else $error("power good dropped above hysteresis level");
  pin_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)     // [RL4]
    (clk_en_in && !sync_if.ext_reset_n) |=> core_reset_out && state == RBS_ST_RESET)
    else $error("pin reset ignored");
  reset_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)   // [RL5]
    (clk_en_in && state == RBS_ST_RESET) |=> irq_mask_out == RBS_IMASK_RESET
      && mode_status_word_out == RBS_MODE_STATUS_WORD_RESET && stack_ptr_out == RBS_STACK_EMPTY)
    else $error("reset did not clear core state");
  rom_start_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)     // [RL6]
    s_reset_exit |=> fetch_addr_out == RBS_ROM_START && fetch_valid_out && !core_reset_out)
    else $error("fetch not at rom start");
  flash_jump_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)    // [RL7]
    (clk_en_in && !reset_cause && state == RBS_ST_ROM_CHECK && boot_code)
      |=> fetch_addr_out == RBS_APP_START && state == RBS_ST_FLASH_RUN)
    else $error("no jump to flash application");
  ext_boot_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)      // [RL8]
    (clk_en_in && !reset_cause && state == RBS_ST_ROM_CHECK && !boot_code) |=> ext_boot_out)
    else $error("external boot not started");
  debug_lock_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)    // [RL9]
    (clk_en_in && boot_code) |=> !debug_ack_out)
    else $error("debugger answered while locked");
  count_restart_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [RL17]
    (clk_en_in && reset_cause) |=> stretch_cnt == '0)
    else $error("stretch count not restarted");
  // A frozen enable would stall any later step, so each check starts on an enabled edge and looks one sys_clk_in edge ahead only
  reset_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)     // [RL2]
    (clk_en_in && state == RBS_ST_RESET) |=> core_reset_out && !fetch_valid_out)
    else $error("fetch valid while in reset");
  erase_first_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)    // [RL11]
    s_erase_busy |=> flash_erase_out && !boot_code_clear_out)
    else $error("boot code cleared before erase finished");
  erase_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)    // [RL11]
    s_erase_end |=> boot_code_clear_out && !boot_code)
    else $error("boot code kept after erase");
  clear_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)     // [RL10]
    (clk_en_in && state != RBS_ST_FLASH_RUN && state != RBS_ST_ERASE) |=> !boot_code_clear_out)
    else $error("boot code cleared outside user program");
  sector_map_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)     // [RL12]
    (clk_en_in && pm_addr_in >= RBS_SECT2_BASE && pm_addr_in <= RBS_SECT2_LAST)
      |=> flash_hit_out && flash_sector_out == 2'h2)
    else $error("application sector not decoded");
  user_erased_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)    // [RL13]
    (clk_en_in && user_bytes_erased_in) |=> user_byte_out == RBS_USER_BYTE_ERASED)
    else $error("erased user byte not zero");
  proc_toggle_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)    // [RL15]
    clk_en_in |=> $changed(processor_clock_output))
    else $error("processor clock did not toggle");
endmodule

// >>> design/rbs_pkg.sv
package rbs_pkg;

  // ----------------------------------------------------------------------
  // Reset stretch and clocking
  // ----------------------------------------------------------------------
  localparam int          RBS_STRETCH_CYCLES = 65536;   // Processor cycles after supply good
  localparam int          RBS_CLK_PERIOD_NS  = 100;     // sys_clk_in period
  localparam int          RBS_SYNC_STAGES    = 3;       // Pin input synchroniser depth

  // ----------------------------------------------------------------------
  // Program addresses and flash layout
  // ----------------------------------------------------------------------
  localparam logic [13:0] RBS_ROM_START      = 14'h0800;
  localparam logic [13:0] RBS_APP_START      = 14'h2200;
  localparam logic [13:0] RBS_SECT0_BASE     = 14'h2000;
  localparam logic [13:0] RBS_SECT1_BASE     = 14'h2100;
  localparam logic [13:0] RBS_SECT2_BASE     = 14'h2200;
  localparam logic [13:0] RBS_SECT2_LAST     = 14'h2fff;
  localparam logic [11:0] RBS_SECT0_WORDS    = 12'h100;
  localparam logic [11:0] RBS_SECT1_WORDS    = 12'h100;
  localparam logic [11:0] RBS_SECT2_WORDS    = 12'he00;
  localparam logic [7:0]  RBS_USER_BYTE_ERASED = 8'h00;
  localparam int          RBS_USER_BYTES     = 4;

  // ----------------------------------------------------------------------
  // Core reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RBS_MODE_STATUS_WORD_RESET    = 8'h00;
  localparam logic [15:0] RBS_IMASK_RESET    = 16'h0000;
  localparam logic [3:0]  RBS_STACK_EMPTY    = 4'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    RBS_ST_RESET,
    RBS_ST_STRETCH,
    RBS_ST_ROM_CHECK,
    RBS_ST_ERASE,
    RBS_ST_FLASH_RUN,
    RBS_ST_EXT_BOOT
  } rbs_state_t;

endpackage

// >>> design/rbs_sync_if.sv
`timescale 1ns/100ps
// Synchronised pin levels passed from the input stage to the sequencer
interface rbs_sync_if;
  logic supply_ok;
  logic supply_low;
  logic ext_reset_n;
  modport src (output supply_ok, output supply_low, output ext_reset_n);
  modport dst (input supply_ok, input supply_low, input ext_reset_n);
endinterface

// >>> design/rbs_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; a change is accepted once stages two and three agree
module rbs_sync
  import rbs_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  input  wire logic clk_en_in,
  // Level
  input  wire logic async_in,
  output logic      level_out
);
  logic [RBS_SYNC_STAGES-1:0] stage;
  wire                        agree = (stage[1] == stage[2]);

  // Shift chain; only stage 1 reads stage 0
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage     <= {RBS_SYNC_STAGES{RESET_VAL}};
      level_out <= RESET_VAL;
    end else if (clk_en_in) begin
      stage <= {stage[RBS_SYNC_STAGES-2:0], async_in};
      if (agree) begin
        level_out <= stage[2];
      end
    end
  end
endmodule

// >>> verification/rbs_supply_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Far side: supply rail with its two comparators and the reset pin driver
// ----------------------------------------------------------------------
module rbs_supply_model #(
  parameter int VRST  = 45,  // Release level in arbitrary supply steps
  parameter int VHYST = 2    // Hysteresis below the release level
) (
  // Commanded supply level and pin pull
  input  wire logic [7:0] supply_level_in,
  input  wire logic       pin_pull_low_in,
  // Comparator outputs and pin level
  output logic            supply_above_vrst_out,
  output logic            supply_below_vhyst_out,
  output logic            ext_reset_n_out
);
  // Two trip levels, so a slow ramp near the threshold cannot chatter
  assign supply_above_vrst_out  = (supply_level_in > 8'(VRST));
  assign supply_below_vhyst_out = (supply_level_in < 8'(VRST - VHYST));
  // Pin has a pull-up; only an active pull takes it low, at any time
  assign ext_reset_n_out = pin_pull_low_in ? 1'b0 : 1'b1;
endmodule

// >>> verification/reset_and_boot_sequencer_tb.sv
`timescale 1ns/100ps
module reset_and_boot_sequencer_tb import rbs_pkg::*;;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        sys_clk_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic        code = 1'b0, er_req = 1'b0, cl_req = 1'b0, er_done = 1'b0;
  logic        dbg_req = 1'b0, pin_low = 1'b0, erased = 1'b0;
  logic [7:0]  level   = 8'h00;
  logic [13:0] pm_addr = 14'h0000;
  logic [1:0]  sel     = 2'h0;
  logic [31:0] ubytes  = 32'h8c4a1f27;
  logic        above, below, ext_n;
  logic        core_reset_out, periph_reset_out, fetch_valid_out, ext_boot_out;
  logic        flash_erase_out, boot_code_clear_out, debug_ack_out, debug_lock_out;
  logic        flash_hit_out, proc_clk;
  logic [3:0]  stack_ptr_out;
  logic [15:0] irq_mask_out;
  logic [7:0]  mode_status_word_out, user_byte_out;
  logic [13:0] fetch_addr_out;
  logic [1:0]  flash_sector_out;
  int          n_mismatch = 0;
  int          n_tests    = 0;

  // Free-running source: never halted, never retuned
  always #50 sys_clk_in = ~sys_clk_in;

  rbs_supply_model sup_u (.supply_level_in(level), .pin_pull_low_in(pin_low), .supply_above_vrst_out(above),
    .supply_below_vhyst_out(below), .ext_reset_n_out(ext_n));

  rbs_sequencer #(.STRETCH_CYCLES(16)) dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(1'b1),
    .supply_above_vrst_in(above), .supply_below_vhyst_in(below), .ext_reset_n_in(ext_n),
    .boot_code_nv_in(code), .secure_erase_req_in(er_req), .boot_clear_req_in(cl_req),
    .erase_done_in(er_done), .debug_req_in(dbg_req), .pm_addr_in(pm_addr), .user_byte_sel_in(sel),
    .user_bytes_nv_in(ubytes), .user_bytes_erased_in(erased), .core_reset_out(core_reset_out),
    .periph_reset_out(periph_reset_out), .stack_ptr_out(stack_ptr_out), .irq_mask_out(irq_mask_out),
    .mode_status_word_out(mode_status_word_out), .fetch_addr_out(fetch_addr_out),
    .fetch_valid_out(fetch_valid_out), .ext_boot_out(ext_boot_out), .flash_erase_out(flash_erase_out),
    .boot_code_clear_out(boot_code_clear_out), .debug_ack_out(debug_ack_out),
    .debug_lock_out(debug_lock_out), .flash_sector_out(flash_sector_out), .flash_hit_out(flash_hit_out),
    .user_byte_out(user_byte_out), .processor_clock_output(proc_clk));

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // Bounded wait: 0 reset low, 1 reset high, 2 erase running, 3 clear pulse
  task automatic wait_sig(input int which, input int max, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      case (which)
        0: hit = (core_reset_out === 1'b0);
        1: hit = (core_reset_out === 1'b1);
        2: hit = (flash_erase_out === 1'b1);
        default: hit = (boot_code_clear_out === 1'b1);
      endcase
      if (!hit && n >= max) begin
        n_mismatch++;
        $display("wrong value wait %0d expected done seen timeout", which);
        stop_test();
      end
      if (!hit) begin
        tick(1);
        n++;
      end
    end
  endtask

  // Power cycle with the given boot code, then judge the whole start-up
  task automatic boot(input logic c);
    int n;
    code = c;
    level = 8'h1e;
    tick(6);
    check("core_reset", core_reset_out, 1);
    check("periph_reset", periph_reset_out, 1);
    level = 8'h32;
    wait_sig(0, 100, n);
    check("stretch_long", n >= 20, 1'h1);
    check("stretch_short", n <= 30, 1);
    check("periph_free", periph_reset_out, 0);
    check("fetch_rom", fetch_addr_out, 14'h0800);
    check("fetch_valid", fetch_valid_out, 1);
    check("stack", stack_ptr_out, RBS_STACK_EMPTY);
    check("irq_mask", irq_mask_out, RBS_IMASK_RESET);
    check("mode_status_word", mode_status_word_out, RBS_MODE_STATUS_WORD_RESET);
    tick(1);
    if (c) begin
      check("fetch_app", fetch_addr_out, 14'h2200);
      check("lock", debug_lock_out, 1);
    end else begin
      check("ext_boot", ext_boot_out, 1);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_flash_boot();
    logic p;
    boot(1'b1);
    dbg_req = 1'b1;
    for (int i = 0; i < 4; i++) begin
      p = proc_clk;
      tick(1);
      check("debug_ack", debug_ack_out, 0);
      check("proc_clk", proc_clk, !p);
    end
    dbg_req = 1'b0;
  endtask

  task automatic sc_ext_boot();
    logic seen;
    boot(1'b0);
    seen = 1'b0;
    dbg_req = 1'b1;
    cl_req = 1'b1;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      seen = seen | debug_ack_out;
      check("clear_refused", boot_code_clear_out, 0);
    end
    check("debug_open", seen, 1);
    dbg_req = 1'b0;
    cl_req = 1'b0;
  endtask

  task automatic sc_pin_and_dip();
    int n;
    pin_low = 1'b1;
    wait_sig(1, 8, n);
    check("pin_periph", periph_reset_out, 1);
    pin_low = 1'b0;
    wait_sig(0, 100, n);
    check("pin_fetch", fetch_addr_out, 14'h0800);
    level = 8'h2c;
    tick(10);
    check("hyst_hold", core_reset_out, 0);
    level = 8'h2a;
    wait_sig(1, 8, n);
    level = 8'h32;
    tick(10);
    level = 8'h1e;
    tick(8);
    level = 8'h32;
    wait_sig(0, 100, n);
    check("dip_restart", n >= 20, 1'h1);
  endtask

  task automatic sc_clear(input logic secure);
    int n;
    boot(1'b1);
    // Flash changes go through the routine requests only, never direct
    er_req = secure;
    cl_req = ~secure;
    if (secure) begin
      wait_sig(2, 8, n);
      check("clear_early", boot_code_clear_out, 0);
      er_req = 1'b0;
      tick(2);
      er_done = 1'b1;
    end
    wait_sig(3, 8, n);
    check("erase_level", flash_erase_out, secure);
    er_done = 1'b0;
    cl_req = 1'b0;
    tick(1);
    check("clear_pulse", boot_code_clear_out, 0);
    check("unlock", debug_lock_out, 0);
  endtask

  task automatic sc_decode();
    logic [13:0] a [7] = '{14'h2000, 14'h20ff, 14'h2100, 14'h21ff, 14'h2200, 14'h2fff, 14'h3000};
    logic [1:0]  s [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 7; i++) begin
      pm_addr = a[i];
      tick(2);
      check("flash_hit", flash_hit_out, i < 6);
      if (i < 6) check("flash_sector", flash_sector_out, s[i]);
    end
    for (int i = 0; i < 4; i++) begin
      sel = 2'(i);
      tick(2);
      check("user_byte", user_byte_out, ubytes[8*i +: 8]);
    end
    erased = 1'b1;
    tick(2);
    check("user_erased", user_byte_out, RBS_USER_BYTE_ERASED);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then every scenario in turn
  initial begin
    tick(4);
    rstn_in = 1'b1;
    sc_flash_boot();
    sc_ext_boot();
    sc_pin_and_dip();
    sc_clear(1'b1);
    sc_clear(1'b0);
    sc_decode();
    stop_test();
  end
endmodule
